// ### hdl/link_cap_regs.svh
`ifndef LINK_CAP_REGS_SVH
`define LINK_CAP_REGS_SVH

// register map (byte addresses; 0x04C is a multiple of four)
`define LCAP_OFF_LINK_CAP 12'h04C
`define LCAP_OFF_CTRL 12'h050
`define LCAP_OFF_UNLOCK 12'h100
`define LCAP_OFF_MODE 12'h104
`define LCAP_OFF_WIDTH_USED 12'h108

// link capabilities field positions
`define LCAP_SPD_LO 0
`define LCAP_SPD_HI 3
`define LCAP_WID_LO 4
`define LCAP_WID_HI 9
`define LCAP_PSS_LO 10
`define LCAP_PSS_HI 11
`define LCAP_L0S_LO 12
`define LCAP_L0S_HI 14
`define LCAP_L1_LO 15
`define LCAP_L1_HI 17
`define LCAP_CLK_BIT 18
`define LCAP_SDE_BIT 19
`define LCAP_LAR_BIT 20
`define LCAP_BWN_BIT 21
`define LCAP_RSV_LO 22
`define LCAP_RSV_HI 23
`define LCAP_PORT_LO 24
`define LCAP_PORT_HI 31

// link control common clock bit
`define LCTL_COMMON_CLOCK_SETTING_BIT 6

// reset and fixed values
`define LCAP_SPD_RST 4'h1
`define LCAP_PSS_VAL 2'h3
`define LCAP_L0S_SEP 3'h5
`define LCAP_L0S_COM 3'h3
`define LCAP_L1_RST 3'h2
`define LCAP_CLK_RST 1'h0
`define LCAP_WID_X1 6'h01

`endif

// ### hdl/link_cap_pkg.sv
package link_cap_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACCESS = 3'b010,
      ST_DONE = 3'b100
   } apb_state_e;

   typedef struct packed {
      logic [5:0] max_width_field;
      logic [2:0] l0s_exit_latency;
      logic [2:0] l1_exit_latency;
      logic clock_removal_tolerance;
      logic surprise_down_capability;
      logic link_active_report_capability;
      logic bandwidth_notify_capability;
   } cap_fields_s;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;
endpackage

// ### hdl/link_capability_register.sv
`timescale 1ns/1ns
`include "link_cap_regs.svh"
module link_capability_register (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [2:0] port_number,
   input wire logic upstream_port,
   input wire logic [5:0] phys_width,
   output logic [5:0] trained_width
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic width_valid(input logic [5:0] w);
      unique case (w)
         6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20: width_valid = 1'b1;
         default: width_valid = 1'b0;
      endcase
   endfunction

   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == `LCAP_OFF_LINK_CAP) || (a == `LCAP_OFF_CTRL) || (a == `LCAP_OFF_UNLOCK) ||
         (a == `LCAP_OFF_MODE) || (a == `LCAP_OFF_WIDTH_USED);
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   link_cap_pkg::cap_fields_s cap_q, cap_d;
   logic init_q, init_d;
   logic unlock_q, unlock_d;
   logic rev11_q, rev11_d;
   logic common_clk_q, common_clk_d;
   logic [7:0] ctrl_lo_q, ctrl_lo_d;
   logic [31:0] prdata_q, prdata_d;
   logic [5:0] trained_q, trained_d;
   link_cap_pkg::apb_state_e st_q, st_d;
   link_cap_pkg::apb_req_s req;
   logic [31:0] cap_word;
   logic wr_fire, rd_fire, cap_rd;

   assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

   // ---------------------------------------------------------------
   // apb handshake: one wait state, ready on the second access cycle
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         link_cap_pkg::ST_IDLE: begin
            if (req.psel && !req.penable) begin
               st_d = link_cap_pkg::ST_ACCESS;
            end
         end
         link_cap_pkg::ST_ACCESS: begin
            if (req.psel && req.penable) begin
               st_d = link_cap_pkg::ST_DONE;
            end
         end
         link_cap_pkg::ST_DONE: begin
            st_d = link_cap_pkg::ST_IDLE;
         end
         default: st_d = link_cap_pkg::ST_IDLE;
      endcase
   end

   assign pready = (st_q == link_cap_pkg::ST_DONE);
   assign pslverr = pready && !known_addr(req.paddr);
   assign wr_fire = pready && req.pwrite && known_addr(req.paddr);
   // read data is loaded on the access edge so it already stands while pready is high
   assign rd_fire = (st_q == link_cap_pkg::ST_ACCESS) && req.psel && req.penable && !req.pwrite;
   assign cap_rd = rd_fire && (req.paddr == `LCAP_OFF_LINK_CAP);
   assign prdata = prdata_q;
   assign trained_width = trained_q;

   // ---------------------------------------------------------------
   // capability word
   // ---------------------------------------------------------------
   always_comb begin
      cap_word = 32'h0;
      cap_word[`LCAP_SPD_HI:`LCAP_SPD_LO] = `LCAP_SPD_RST;
      cap_word[`LCAP_WID_HI:`LCAP_WID_LO] = cap_q.max_width_field;
      cap_word[`LCAP_PSS_HI:`LCAP_PSS_LO] = `LCAP_PSS_VAL;
      // the latency follows the live common clock setting, so it tracks link control writes
      cap_word[`LCAP_L0S_HI:`LCAP_L0S_LO] = common_clk_q ? `LCAP_L0S_COM : `LCAP_L0S_SEP;
      cap_word[`LCAP_L1_HI:`LCAP_L1_LO] = cap_q.l1_exit_latency;
      cap_word[`LCAP_CLK_BIT] = cap_q.clock_removal_tolerance;
      cap_word[`LCAP_SDE_BIT] = cap_q.surprise_down_capability;
      cap_word[`LCAP_LAR_BIT] = cap_q.link_active_report_capability;
      cap_word[`LCAP_BWN_BIT] = cap_q.bandwidth_notify_capability;
      cap_word[`LCAP_PORT_HI:`LCAP_PORT_LO] = {5'h00, port_number};
   end

   // ---------------------------------------------------------------
   // register next state
   // ---------------------------------------------------------------
   always_comb begin
      cap_d = cap_q;
      init_d = 1'b1;
      unlock_d = unlock_q;
      rev11_d = rev11_q;
      common_clk_d = common_clk_q;
      ctrl_lo_d = ctrl_lo_q;
      prdata_d = prdata_q;
      if (!init_q) begin
         // straps are taken one cycle after reset release, never under the async reset
         cap_d.max_width_field = phys_width;
         cap_d.l1_exit_latency = `LCAP_L1_RST;
         cap_d.clock_removal_tolerance = `LCAP_CLK_RST;
         cap_d.surprise_down_capability = !upstream_port;
         cap_d.link_active_report_capability = !upstream_port;
         cap_d.bandwidth_notify_capability = !upstream_port && !rev11_q;
      end else if (wr_fire) begin
         unique case (req.paddr)
            `LCAP_OFF_LINK_CAP: begin
               if (unlock_q) begin
                  cap_d.max_width_field = req.pwdata[`LCAP_WID_HI:`LCAP_WID_LO];
                  cap_d.l1_exit_latency = req.pwdata[`LCAP_L1_HI:`LCAP_L1_LO];
                  cap_d.clock_removal_tolerance = req.pwdata[`LCAP_CLK_BIT];
                  cap_d.surprise_down_capability = req.pwdata[`LCAP_SDE_BIT];
                  // link active and bandwidth notify stay zero upstream
                  cap_d.link_active_report_capability = req.pwdata[`LCAP_LAR_BIT] && !upstream_port;
                  cap_d.bandwidth_notify_capability = req.pwdata[`LCAP_BWN_BIT] && !upstream_port;
               end
            end
            `LCAP_OFF_CTRL: begin
               ctrl_lo_d = req.pwdata[7:0];
               common_clk_d = req.pwdata[`LCTL_COMMON_CLOCK_SETTING_BIT];
            end
            `LCAP_OFF_UNLOCK: unlock_d = req.pwdata[0];
            `LCAP_OFF_MODE: begin
               rev11_d = req.pwdata[0];
               if (req.pwdata[0]) begin
                  cap_d.bandwidth_notify_capability = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (rd_fire) begin
         unique case (req.paddr)
            `LCAP_OFF_LINK_CAP: prdata_d = cap_word;
            `LCAP_OFF_CTRL: prdata_d = {24'h000000, ctrl_lo_q[7:7], common_clk_q, 1'b0, ctrl_lo_q[4:0]};
            `LCAP_OFF_UNLOCK: prdata_d = {31'h00000000, unlock_q};
            `LCAP_OFF_MODE: prdata_d = {31'h00000000, rev11_q};
            `LCAP_OFF_WIDTH_USED: prdata_d = {26'h0000000, trained_q};
            default: prdata_d = 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // width used by link training
   // ---------------------------------------------------------------
   always_comb begin
      trained_d = width_valid(cap_q.max_width_field) ? cap_q.max_width_field : `LCAP_WID_X1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_q <= '0;
         init_q <= 1'b0;
         unlock_q <= 1'b0;
         rev11_q <= 1'b0;
         common_clk_q <= 1'b0;
         ctrl_lo_q <= 8'h00;
         prdata_q <= 32'h0;
         trained_q <= `LCAP_WID_X1;
         st_q <= link_cap_pkg::ST_IDLE;
      end else begin
         cap_q <= cap_d;
         init_q <= init_d;
         unlock_q <= unlock_d;
         rev11_q <= rev11_d;
         common_clk_q <= common_clk_d;
         ctrl_lo_q <= ctrl_lo_d;
         prdata_q <= prdata_d;
         trained_q <= trained_d;
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // fixed and read-only fields are judged on the read path, so a broken read mux trips them too
   speed_field_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd |=> prdata[`LCAP_SPD_HI:`LCAP_SPD_LO] == `LCAP_SPD_RST)
      else $error("speed field not 1");

   power_support_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd |=> prdata[`LCAP_PSS_HI:`LCAP_PSS_LO] == `LCAP_PSS_VAL)
      else $error("power support not 3");

   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd |=> prdata[`LCAP_RSV_HI:`LCAP_RSV_LO] == 2'h0)
      else $error("reserved bits set");

   port_number_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd |=> prdata[`LCAP_PORT_HI:`LCAP_PORT_LO] == {5'h00, $past(port_number)})
      else $error("port number wrong");

   width_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd |=> prdata[`LCAP_WID_HI:`LCAP_WID_LO] == $past(cap_q.max_width_field))
      else $error("width field read wrong");

   l1_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd |=> prdata[`LCAP_L1_HI:`LCAP_L1_LO] == $past(cap_q.l1_exit_latency))
      else $error("l1 latency read wrong");

   surprise_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd |=> prdata[`LCAP_SDE_BIT] == $past(cap_q.surprise_down_capability))
      else $error("surprise down read wrong");

   // the latency code follows the live common clock bit, so a control write changes it at once
   l0s_separate_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd && !common_clk_q |=> prdata[`LCAP_L0S_HI:`LCAP_L0S_LO] == `LCAP_L0S_SEP)
      else $error("separate clock code wrong");

   l0s_common_a: assert property (@(posedge clk) disable iff (!rst_n)
      cap_rd && common_clk_q |=> prdata[`LCAP_L0S_HI:`LCAP_L0S_LO] == `LCAP_L0S_COM)
      else $error("common clock code wrong");

   common_clock_setting_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_fire && req.paddr == `LCAP_OFF_CTRL |=> common_clk_q == $past(req.pwdata[`LCTL_COMMON_CLOCK_SETTING_BIT]))
      else $error("common clock not taken");

   // the trained width follows the field only for the listed lane counts
   width_x1_fallback_a: assert property (@(posedge clk) disable iff (!rst_n)
      init_q && !(cap_q.max_width_field inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20})
      |=> trained_q == `LCAP_WID_X1)
      else $error("bad width not x1");

   width_valid_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
      init_q && (cap_q.max_width_field inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20})
      |=> trained_q == $past(cap_q.max_width_field))
      else $error("valid width not used");

   width_init_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      !init_q |=> cap_q.max_width_field == $past(phys_width))
      else $error("width not loaded");

   width_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_fire && unlock_q && req.paddr == `LCAP_OFF_LINK_CAP
      |=> cap_q.max_width_field == $past(req.pwdata[`LCAP_WID_HI:`LCAP_WID_LO]))
      else $error("width not written");

   // straps land on the first edge after reset release
   l1_default_a: assert property (@(posedge clk) disable iff (!rst_n)
      !init_q |=> cap_q.l1_exit_latency == `LCAP_L1_RST)
      else $error("l1 latency default wrong");

   clock_removal_a: assert property (@(posedge clk) disable iff (!rst_n)
      !init_q |=> cap_q.clock_removal_tolerance == `LCAP_CLK_RST)
      else $error("clock removal bit set");

   surprise_down_a: assert property (@(posedge clk) disable iff (!rst_n)
      !init_q |=> cap_q.surprise_down_capability == !$past(upstream_port))
      else $error("surprise down default wrong");

   link_active_dflt_a: assert property (@(posedge clk) disable iff (!rst_n)
      !init_q |=> cap_q.link_active_report_capability == !$past(upstream_port))
      else $error("link active default wrong");

   bw_notify_dflt_a: assert property (@(posedge clk) disable iff (!rst_n)
      !init_q && !rev11_q |=> cap_q.bandwidth_notify_capability == !$past(upstream_port))
      else $error("bandwidth notify default wrong");

   rev11_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_fire && req.paddr == `LCAP_OFF_MODE && req.pwdata[0] |=> !cap_q.bandwidth_notify_capability)
      else $error("bandwidth notify not cleared");

   upstream_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      init_q && upstream_port |-> !cap_q.link_active_report_capability && !cap_q.bandwidth_notify_capability)
      else $error("upstream bit set");

   // a mode write may clear bandwidth notify even while the fields are locked
   locked_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      init_q && !unlock_q && !(wr_fire && req.paddr == `LCAP_OFF_MODE) |=> $stable(cap_q))
      else $error("locked field changed");

   unlocked_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_fire && unlock_q && req.paddr == `LCAP_OFF_LINK_CAP
      |=> cap_q.l1_exit_latency == $past(req.pwdata[`LCAP_L1_HI:`LCAP_L1_LO]))
      else $error("unlocked write lost");

endmodule

// ### bench/link_capability_register_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module link_capability_register_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic [2:0] port_number = 3'h5;
   logic upstream_port = 1'b0;
   logic [5:0] phys_width = 6'h20;
   logic [5:0] trained_width;
   logic [31:0] rd;
   logic er;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;

   link_capability_register link_capability_register_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .port_number(port_number), .upstream_port(upstream_port),
      .phys_width(phys_width), .trained_width(trained_width));

   // ----------------------------------------
   // clock, reset and timeout
   // ----------------------------------------
   initial begin
      forever #2 clk = ~clk;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end

   task automatic do_reset(input logic [2:0] p, input logic up);
      @(posedge clk);
      rst_n <= 1'b0;
      // straps move only while reset is held
      port_number <= p;
      upstream_port <= up;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   // ----------------------------------------
   // bus cycles and expectations
   // ----------------------------------------
   // pready, prdata and pslverr are read at the edge that ends the access, before that edge's updates land
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] cap(logic [2:0] p, logic up, logic [5:0] w, logic [2:0] l0s, logic bw);
      return {5'h00, p, 2'h0, bw, ~up, ~up, 1'b0, 3'h2, l0s, 2'h3, w, 4'h1};
   endfunction

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      apb(1'b0, 12'h04C, 32'h00000000);
      `CHK(rd, cap(3'h5, 1'b0, 6'h20, 3'h5, 1'b1))
      `CHK(trained_width, 6'h20)
   endtask

   task automatic t_locked();
      apb(1'b1, 12'h04C, 32'hFFFFFFFF);
      apb(1'b0, 12'h04C, 32'h00000000);
      `CHK(rd, cap(3'h5, 1'b0, 6'h20, 3'h5, 1'b1))
   endtask

   task automatic t_width();
      logic [5:0] codes[10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h3F, 6'h20};
      logic [5:0] w;
      apb(1'b1, 12'h100, 32'h00000001);
      foreach (codes[i]) begin
         w = codes[i];
         apb(1'b1, 12'h04C, cap(3'h5, 1'b0, w, 3'h5, 1'b1) | 32'h00C0000F);
         apb(1'b0, 12'h04C, 32'h00000000);
         `CHK(rd, cap(3'h5, 1'b0, w, 3'h5, 1'b1))
         if (!(w inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20})) w = 6'h01;
         apb(1'b0, 12'h108, 32'h00000000);
         `CHK(trained_width, w)
         `CHK(rd, {26'h0000000, w})
      end
   endtask

   task automatic t_common_clock_setting();
      apb(1'b1, 12'h050, 32'h00000040);
      apb(1'b0, 12'h04C, 32'h00000000);
      `CHK(rd, cap(3'h5, 1'b0, 6'h20, 3'h3, 1'b1))
      apb(1'b1, 12'h050, 32'h00000000);
      apb(1'b0, 12'h04C, 32'h00000000);
      `CHK(rd, cap(3'h5, 1'b0, 6'h20, 3'h5, 1'b1))
   endtask

   task automatic t_rev11();
      apb(1'b1, 12'h104, 32'h00000001);
      apb(1'b0, 12'h04C, 32'h00000000);
      `CHK(rd, cap(3'h5, 1'b0, 6'h20, 3'h5, 1'b0))
   endtask

   task automatic t_unmapped();
      apb(1'b0, 12'h200, 32'h00000000);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h00000000)
   endtask

   task automatic t_upstream();
      do_reset(3'h7, 1'b1);
      apb(1'b0, 12'h04C, 32'h00000000);
      `CHK(rd, cap(3'h7, 1'b1, 6'h20, 3'h5, 1'b0))
      apb(1'b1, 12'h100, 32'h00000001);
      apb(1'b1, 12'h04C, cap(3'h7, 1'b1, 6'h20, 3'h5, 1'b0) | 32'h00380000);
      apb(1'b0, 12'h04C, 32'h00000000);
      `CHK(rd, cap(3'h7, 1'b1, 6'h20, 3'h5, 1'b0) | 32'h00080000)
   endtask

   // ----------------------------------------
   // main sequence and verdict
   // ----------------------------------------
   task automatic report_and_stop();
      $display("compared %0d, wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_locked();
      t_width();
      t_common_clock_setting();
      t_rev11();
      t_unmapped();
      t_upstream();
      report_and_stop();
   end
endmodule
